// file: ident_regs_pkg.sv
// Purpose: constants and types for the core identification register bank
// Assumes: system coprocessor read port decoded by opcode1, primary, secondary, opcode2
// Notes:   values are fixed or pin-derived; nothing here is writable
`default_nettype none
package ident_regs_pkg;

  // coprocessor access selector
  typedef struct packed {
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
  } cp_sel_t;

  // access request carried as one bundle
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       priv_one;
    logic       secure;
    cp_sel_t    sel;
  } cp_req_t;

  // selectors of the three registers
  localparam cp_sel_t SEL_AFFINITY = '{opc1: 3'h0, crn: 4'h0, crm: 4'h0, opc2: 3'h5};
  localparam cp_sel_t SEL_REVISION = '{opc1: 3'h0, crn: 4'h0, crm: 4'h0, opc2: 3'h6};
  localparam cp_sel_t SEL_FEATURE  = '{opc1: 3'h0, crn: 4'h0, crm: 4'h1, opc2: 3'h0};

  // affinity field positions and fixed values
  localparam int         AFF_MP_FORMAT_BIT   = 31;
  localparam int         AFF_UNIPROC_BIT     = 30;
  localparam int         AFF_MT_BIT          = 24;
  localparam int         AFF_CLUSTER_LSB     = 8;
  localparam int         AFF_CORE_LSB        = 0;
  localparam logic       AFF_MP_FORMAT_VAL   = 1'b1;
  localparam logic       AFF_UNIPROC_VAL     = 1'b0;
  localparam logic       AFF_MT_VAL          = 1'b0;

  // feature register field positions and values
  localparam int         PFR_EXEC_ENV_LSB    = 12;
  localparam int         PFR_BYTECODE_LSB    = 8;
  localparam int         PFR_COMPACT_LSB     = 4;
  localparam int         PFR_NATIVE_LSB      = 0;
  localparam logic [3:0] PFR_EXEC_ENV_VAL    = 4'h1;
  localparam logic [3:0] PFR_BYTECODE_VAL    = 4'h1;
  localparam logic [3:0] PFR_COMPACT_VAL     = 4'h3;
  localparam logic [3:0] PFR_NATIVE_VAL      = 4'h1;

  // revision detail default, arbitrary value chosen for this build
  localparam logic [31:0] REVISION_DETAIL_DEFAULT = 32'h0000_0000;

  // reset value of the read data output
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

endpackage

`default_nettype wire

// file: cpu_identification_regs.sv
// Purpose: read-only identification registers of one core in a cluster
// Assumes: request is presented for one cycle; answer follows one cycle later
// Notes:   write or unprivileged access is refused with an undefined flag
//
// What this block does
// - Affinity bit 31 always reads one for the multiprocessing register format.
// - Affinity bit 30 reads zero since the core is part of a multiprocessor system.
// - Affinity bit 24 reads zero since the lowest level is not multithreaded.
// - Affinity bits 11:8 return the value on the cluster number pins.
// - Affinity bits 1:0 hold the core index within the cluster, 0 to 3.
// - All three registers are read-only and reachable only at privilege level one or higher.
// - Each register is one copy giving the same value in secure and non-secure state.
// - The affinity register is read with opcode1 0, c0, c0, opcode2 5.
// - The revision detail register gives a 32-bit implementation-chosen value.
// - The revision detail register is read with opcode1 0, c0, c0, opcode2 6.
// - Feature bits 15:12 read 0x1 for the execution-environment instruction set.
// - Feature bits 11:8 read 0x1 for the trivial bytecode extension.
// - Feature bits 7:4 read 0x3 for the full compact instruction encoding.
// - Feature bits 3:0 read 0x1 for the native 32-bit instruction set.
// - The first feature register is read with opcode1 0, c0, c1, opcode2 0.
`timescale 1ns/1ps
`default_nettype none

module cpu_identification_regs #(
  parameter logic [31:0] REVISION_DETAIL_VALUE = ident_regs_pkg::REVISION_DETAIL_DEFAULT
) (
  input  wire logic                    clk_sys_i,           // core clock, 125 MHz
  input  wire logic                    rstn_i,              // synchronous reset, active low
  input  wire ident_regs_pkg::cp_req_t cp_req_i,            // coprocessor access request
  input  wire logic [3:0]              cluster_number_pins_i, // cluster number strap
  input  wire logic [1:0]              core_index_i,        // core index strap
  output logic                         cp_ack_o,            // answer valid, one cycle
  output logic                         cp_undef_o,          // access refused, one cycle
  output logic [31:0]                  cp_rdata_o           // read data
);

  // which of the three registers a selector names
  typedef enum {
    REG_NONE,
    REG_AFFINITY,
    REG_REVISION,
    REG_FEATURE
  } reg_id_t;

  localparam int PFR_FIELDS = 4;
  localparam int FIELD_W    = 4;

  // request fields, unpacked once
  logic                    req_valid;
  logic                    req_write;
  logic                    req_priv_one;
  ident_regs_pkg::cp_sel_t req_sel;

  // decode and refusal causes
  reg_id_t                 reg_id;
  logic                    hit_affinity;
  logic                    hit_revision;
  logic                    hit_feature;
  logic                    write_refused;
  logic                    priv_refused;
  logic                    sel_refused;
  logic                    ok_next;
  logic                    ack_next;
  logic                    undef_next;

  // named fields of the affinity register
  logic                    mp_format_flag;
  logic                    uniproc_flag;
  logic                    multithread_flag;
  logic [3:0]              cluster_number_field;
  logic [1:0]              core_index_field;

  // named fields of the first feature register
  logic [3:0]              exec_env_isa_support;
  logic [3:0]              bytecode_ext_support;
  logic [3:0]              compact_isa_support;
  logic [3:0]              native_isa_support;
  logic [3:0]              feature_field [PFR_FIELDS];
  logic [31:0]             feature_part [PFR_FIELDS];

  // register images
  logic [31:0]             affinity_raw;
  logic [31:0]             affinity_value;
  logic [31:0]             feature_raw;
  logic [31:0]             feature_value;
  logic [31:0]             revision_detail_value;
  logic [31:0]             rdata_next;
  logic [31:0]             rdata_out_next;

  // strap registers
  logic [3:0]              cluster_reg;
  logic [1:0]              core_reg;

  // decodes a selector against one register address, field by field
  function automatic logic sel_match(input ident_regs_pkg::cp_sel_t a,
                                     input ident_regs_pkg::cp_sel_t b);
    logic same;
    same = 1'b1;
    if (a.opc1 != b.opc1) begin
      same = 1'b0;
    end
    if (a.crn != b.crn) begin
      same = 1'b0;
    end
    if (a.crm != b.crm) begin
      same = 1'b0;
    end
    if (a.opc2 != b.opc2) begin
      same = 1'b0;
    end
    return same;
  endfunction

  // names the register a selector points at, or none
  function automatic reg_id_t decode_sel(input ident_regs_pkg::cp_sel_t s);
    reg_id_t id;
    id = REG_NONE;
    if (sel_match(s, ident_regs_pkg::SEL_AFFINITY)) begin
      id = REG_AFFINITY;
    end
    if (sel_match(s, ident_regs_pkg::SEL_REVISION)) begin
      id = REG_REVISION;
    end
    if (sel_match(s, ident_regs_pkg::SEL_FEATURE)) begin
      id = REG_FEATURE;
    end
    return id;
  endfunction

  // ones over a field of the given width starting at lsb
  function automatic logic [31:0] field_mask(input int lsb,
                                             input int width);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 32; b++) begin
      if (b >= lsb && b < lsb + width) begin
        m[b] = 1'b1;
      end
    end
    return m;
  endfunction

  // position of each feature slot, lowest field first
  function automatic int pfr_lsb(input int idx);
    case (idx)
      0:       pfr_lsb = ident_regs_pkg::PFR_NATIVE_LSB;
      1:       pfr_lsb = ident_regs_pkg::PFR_COMPACT_LSB;
      2:       pfr_lsb = ident_regs_pkg::PFR_BYTECODE_LSB;
      default: pfr_lsb = ident_regs_pkg::PFR_EXEC_ENV_LSB;
    endcase
  endfunction

  // a four-bit field moved up to its place in a 32-bit word
  function automatic logic [31:0] nibble_at(input logic [3:0] value,
                                            input int         lsb);
    logic [31:0] w;
    w = {28'h000_0000, value};
    return w << lsb;
  endfunction

  // only defined fields may carry ones
  localparam logic [31:0] AFFINITY_USED =
      field_mask(ident_regs_pkg::AFF_MP_FORMAT_BIT, 1)
    | field_mask(ident_regs_pkg::AFF_UNIPROC_BIT, 1)
    | field_mask(ident_regs_pkg::AFF_MT_BIT, 1)
    | field_mask(ident_regs_pkg::AFF_CLUSTER_LSB, 4)
    | field_mask(ident_regs_pkg::AFF_CORE_LSB, 2);
  localparam logic [31:0] FEATURE_USED =
      field_mask(ident_regs_pkg::PFR_NATIVE_LSB, FIELD_W)
    | field_mask(ident_regs_pkg::PFR_COMPACT_LSB, FIELD_W)
    | field_mask(ident_regs_pkg::PFR_BYTECODE_LSB, FIELD_W)
    | field_mask(ident_regs_pkg::PFR_EXEC_ENV_LSB, FIELD_W);

  // security state unused, one copy serves both
  assign req_valid    = cp_req_i.valid;
  assign req_write    = cp_req_i.write;
  assign req_priv_one = cp_req_i.priv_one;
  assign req_sel      = cp_req_i.sel;

  always_comb begin
    reg_id = decode_sel(req_sel);
  end

  assign hit_affinity = (reg_id == REG_AFFINITY);
  assign hit_revision = (reg_id == REG_REVISION);
  assign hit_feature  = (reg_id == REG_FEATURE);

  assign write_refused = req_write;
  assign priv_refused  = !req_priv_one;
  assign sel_refused   = !(hit_affinity || hit_revision || hit_feature);
  assign ok_next       = !write_refused && !priv_refused && !sel_refused;

  always_comb begin
    ack_next   = 1'b0;
    undef_next = 1'b0;
    if (req_valid) begin
      if (ok_next) begin
        ack_next = 1'b1;
      end else begin
        undef_next = 1'b1;
      end
    end
  end

  // straps are caught every cycle and not reset; a read in the first
  // cycle after reset would see whatever the pins showed one edge before
  always_ff @(posedge clk_sys_i) begin
    cluster_reg <= cluster_number_pins_i;
  end

  always_ff @(posedge clk_sys_i) begin
    core_reg <= core_index_i;
  end

  assign mp_format_flag = ident_regs_pkg::AFF_MP_FORMAT_VAL;

  assign uniproc_flag = ident_regs_pkg::AFF_UNIPROC_VAL;

  assign multithread_flag = ident_regs_pkg::AFF_MT_VAL;

  assign cluster_number_field = cluster_reg;

  assign core_index_field = core_reg;

  always_comb begin
    affinity_raw = 32'h0000_0000;
    // format flag
    affinity_raw[ident_regs_pkg::AFF_MP_FORMAT_BIT] = mp_format_flag;
    // uniprocessor flag
    affinity_raw[ident_regs_pkg::AFF_UNIPROC_BIT] = uniproc_flag;
    // multithread flag
    affinity_raw[ident_regs_pkg::AFF_MT_BIT] = multithread_flag;
    // cluster number
    affinity_raw[ident_regs_pkg::AFF_CLUSTER_LSB +: 4] = cluster_number_field;
    // core index
    affinity_raw[ident_regs_pkg::AFF_CORE_LSB +: 2] = core_index_field;
  end

  assign affinity_value = affinity_raw & AFFINITY_USED;

  assign exec_env_isa_support = ident_regs_pkg::PFR_EXEC_ENV_VAL;

  assign bytecode_ext_support = ident_regs_pkg::PFR_BYTECODE_VAL;

  assign compact_isa_support = ident_regs_pkg::PFR_COMPACT_VAL;

  assign native_isa_support = ident_regs_pkg::PFR_NATIVE_VAL;

  // slots in the order of pfr_lsb
  assign feature_field[0] = native_isa_support;
  assign feature_field[1] = compact_isa_support;
  assign feature_field[2] = bytecode_ext_support;
  assign feature_field[3] = exec_env_isa_support;

  // one generated slot per feature field
  genvar g;
  generate
    for (g = 0; g < PFR_FIELDS; g++) begin : g_pfr
      assign feature_part[g] = nibble_at(feature_field[g], pfr_lsb(g));
    end
  endgenerate

  always_comb begin
    feature_raw = 32'h0000_0000;
    for (int f = 0; f < PFR_FIELDS; f++) begin
      feature_raw = feature_raw | feature_part[f];
    end
  end

  assign feature_value = feature_raw & FEATURE_USED;

  assign revision_detail_value = REVISION_DETAIL_VALUE;

  always_comb begin
    case (reg_id)
      REG_AFFINITY: begin
        rdata_next = affinity_value;
      end
      REG_REVISION: begin
        rdata_next = revision_detail_value;
      end
      REG_FEATURE: begin
        rdata_next = feature_value;
      end
      default: begin
        rdata_next = ident_regs_pkg::RDATA_RESET;
      end
    endcase
  end

  // refused accesses return zero so nothing leaks to less-privileged code
  always_comb begin
    rdata_out_next = ident_regs_pkg::RDATA_RESET;
    if (ack_next) begin
      rdata_out_next = rdata_next;
    end
  end

  // every output comes straight from a flip-flop
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cp_ack_o <= 1'b0;
    end else begin
      cp_ack_o <= ack_next;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cp_undef_o <= 1'b0;
    end else begin
      cp_undef_o <= undef_next;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cp_rdata_o <= ident_regs_pkg::RDATA_RESET;
    end else begin
      cp_rdata_o <= rdata_out_next;
    end
  end

endmodule

`default_nettype wire

// file: cpu_identification_regs_asserts.sv
// Purpose: port assertions for the identification bank
// Assumes: answer one cycle after the taking edge
// Notes:   straps must be steady one cycle before a read
`timescale 1ns/1ps
`default_nettype none
module cpu_identification_regs_asserts #(
  parameter logic [31:0] REVISION_DETAIL_VALUE = 32'h0000_0000
) (
  input wire logic                    clk_sys_i,             // clock
  input wire logic                    rstn_i,                // reset
  input wire ident_regs_pkg::cp_req_t cp_req_i,              // request
  input wire logic [3:0]              cluster_number_pins_i, // strap
  input wire logic [1:0]              core_index_i,          // strap
  input wire logic                    cp_ack_o,              // ack
  input wire logic                    cp_undef_o,            // refused
  input wire logic [31:0]             cp_rdata_o             // data
);
  wire logic ok     = cp_req_i.valid && !cp_req_i.write && cp_req_i.priv_one;
  wire logic rd_aff = ok && cp_req_i.sel == ident_regs_pkg::SEL_AFFINITY;
  wire logic rd_rev = ok && cp_req_i.sel == ident_regs_pkg::SEL_REVISION;
  wire logic rd_pfr = ok && cp_req_i.sel == ident_regs_pkg::SEL_FEATURE;
  wire logic rd_any = rd_aff || rd_rev || rd_pfr;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  property p_ack; rd_any |=> cp_ack_o && !cp_undef_o; endproperty
  property p_ref; (cp_req_i.valid && !rd_any) |=> cp_undef_o && !cp_ack_o && cp_rdata_o == 0;
  endproperty
  property p_idle; !cp_req_i.valid |=> !cp_ack_o && !cp_undef_o && cp_rdata_o == 0; endproperty
  property p_fix; rd_aff |=> cp_rdata_o[31:12] == 20'h8000_0 && cp_rdata_o[7:2] == 0; endproperty
  property p_clu; rd_aff && $stable(cluster_number_pins_i) |=>
    cp_rdata_o[11:8] == $past(cluster_number_pins_i); endproperty
  property p_core; rd_aff && $stable(core_index_i) |=> cp_rdata_o[1:0] == $past(core_index_i);
  endproperty
  property p_rev; rd_rev |=> cp_rdata_o == REVISION_DETAIL_VALUE; endproperty
  property p_pfr; rd_pfr |=> cp_rdata_o == 32'h0000_1131; endproperty
  a_ack: assert property (p_ack) else $error("good read not acknowledged");
  a_ref: assert property (p_ref) else $error("bad access not refused");
  a_idle: assert property (p_idle) else $error("answer without request");
  a_fix: assert property (p_fix) else $error("affinity fixed bits wrong");
  a_clu: assert property (p_clu) else $error("cluster field wrong");
  a_core: assert property (p_core) else $error("core field wrong");
  a_rev: assert property (p_rev) else $error("revision value wrong");
  a_pfr: assert property (p_pfr) else $error("feature value wrong");
  c_aff: cover property (rd_aff);
  c_rev: cover property (rd_rev);
  c_ref: cover property (cp_req_i.valid && !rd_any);
endmodule
bind cpu_identification_regs cpu_identification_regs_asserts #(
  .REVISION_DETAIL_VALUE(REVISION_DETAIL_VALUE)) u_chk (.clk_sys_i(clk_sys_i),
  .rstn_i(rstn_i), .cp_req_i(cp_req_i), .cluster_number_pins_i(cluster_number_pins_i),
  .core_index_i(core_index_i), .cp_ack_o(cp_ack_o), .cp_undef_o(cp_undef_o),
  .cp_rdata_o(cp_rdata_o));
`default_nettype wire

// file: cpu_identification_regs_tb.sv
// Purpose: random accesses to the identification bank against a model
// Assumes: inputs change on the falling edge
// Notes:   straps settle one cycle before each request
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module cpu_identification_regs_tb;
  localparam logic [31:0] REV_VAL = 32'h5a3c_0f96; // arbitrary build value
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  ident_regs_pkg::cp_req_t req = '0;
  logic [3:0] clus = 4'h0;
  logic [1:0] core = 2'h0;
  logic ack, undef;
  logic [31:0] rdata;
  logic [15:0] lf = 16'h2a04;
  int fails = 0;
  int n_checks = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  cpu_identification_regs #(.REVISION_DETAIL_VALUE(REV_VAL)) DUT (.clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i), .cp_req_i(req), .cluster_number_pins_i(clus), .core_index_i(core),
    .cp_ack_o(ack), .cp_undef_o(undef), .cp_rdata_o(rdata));
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #(8 * 1500);
    fails++;
    give_verdict();
  end
  initial begin
    logic hit;
    logic [31:0] exp;
    repeat (12) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    for (int i = 0; i < 300; i++) begin
      lf = step(lf);
      {clus, core} = lf[15:10];
      @(negedge clk_sys_i);
      req = {1'b1, lf[0] & lf[1], lf[2] | lf[3], lf[4], lf[13:0]};
      case (lf[6:5])
        2'd0: req.sel = ident_regs_pkg::SEL_AFFINITY;
        2'd1: req.sel = ident_regs_pkg::SEL_REVISION;
        2'd2: req.sel = ident_regs_pkg::SEL_FEATURE;
        default: ;
      endcase
      hit = !req.write && req.priv_one;
      if (req.sel == ident_regs_pkg::SEL_AFFINITY) exp = {20'h8000_0, clus, 6'h0, core};
      else if (req.sel == ident_regs_pkg::SEL_REVISION) exp = REV_VAL;
      else if (req.sel == ident_regs_pkg::SEL_FEATURE) exp = 32'h0000_1131;
      else hit = 1'b0;
      @(negedge clk_sys_i);
      `CHK("ack", hit, ack)
      `CHK("undef", !hit, undef)
      `CHK("rdata", hit ? exp : 32'h0, rdata)
      req.valid = 1'b0;
    end
    $display("random reads done");
    give_verdict();
  end
endmodule
`default_nettype wire
